// >>> hw/lgpd_pkg.sv
// Constants and types shared by the bitmap pixel decoder and its byte FIFO.
// Assumes a single 250 MHz dot clock with one dot per clock.
package lgpd_pkg;

  // ==========================================================
  // Modes and serialiser states
  typedef enum logic [1:0] {
    LGPD_LORES = 2'b00,
    LGPD_SINGLE = 2'b01,
    LGPD_DOUBLE = 2'b10
  } lgpd_mode_type;

  typedef enum logic [1:0] {
    LGPD_IDLE = 2'b00,
    LGPD_SHIFT = 2'b01,
    LGPD_PAD = 2'b10
  } lgpd_state_type;

  // ==========================================================
  // Line geometry
  localparam logic [5:0] LAST_BYTE = 6'h27;
  localparam logic [3:0] SINGLE_LAST_DOT = 4'h6;
  localparam logic [3:0] DOUBLE_LAST_DOT = 4'hD;
  localparam logic [9:0] SINGLE_LINE_DOTS = 10'h118;
  localparam logic [9:0] DOUBLE_LINE_DOTS = 10'h230;
  localparam logic [7:0] MIX_FIRST_ROW = 8'hA0;
  localparam int LORES_HALF_BIT = 2;
  localparam int COLSET_BIT = 7;

  // ==========================================================
  // Palette indices
  localparam logic [3:0] COL_BLACK = 4'h0;
  localparam logic [3:0] COL_PURPLE = 4'h3;
  localparam logic [3:0] COL_BLUE = 4'h6;
  localparam logic [3:0] COL_ORANGE = 4'h9;
  localparam logic [3:0] COL_GREEN = 4'hC;
  localparam logic [3:0] COL_WHITE = 4'hF;

  // ==========================================================
  // Display buffer bases
  localparam logic [15:0] TEXT_PAGE1 = 16'h0400;
  localparam logic [15:0] TEXT_PAGE2 = 16'h0800;
  localparam logic [15:0] BITMAP_PAGE1 = 16'h2000;
  localparam logic [15:0] BITMAP_PAGE2 = 16'h4000;

  // ==========================================================
  // FIFO word: row, aux byte, main byte
  localparam int FIFO_DEPTH = 16;
  localparam int WORD_WIDTH = 24;
  localparam int MAIN_LSB = 0;
  localparam int AUX_LSB = 8;
  localparam int ROW_LSB = 16;
  localparam logic [1:0] RESET_STATE = 2'b00;

endpackage

// >>> hw/lgpd_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes both sides run on clk_in; DEPTH is a power of two.
`timescale 1ns/1ns
`default_nettype none
module lgpd_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Fill side
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  input wire logic [WIDTH-1:0] wr_data_in,
  // Drain side
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic [WIDTH-1:0] rd_data_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  logic full;
  logic empty;

  assign empty = wr_ptr_reg == rd_ptr_reg;
  assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign wr_ready_out = !full;
  assign rd_valid_out = !empty;
  assign rd_data_out = mem_reg[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge clk_in) begin
    if (wr_valid_in && !full) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      wr_ptr_reg <= '0;
    end else if (wr_valid_in && !full) begin
      wr_ptr_reg <= wr_ptr_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rd_ptr_reg <= '0;
    end else if (rd_ready_in && !empty) begin
      rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end

  a_no_overrun: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE25
    full |-> ##1 (wr_ptr_reg == $past(wr_ptr_reg)))
    else $error("fifo pointer moved while full");
endmodule
`default_nettype wire

// >>> hw/lgpd_pixel_decoder.sv
// Bitmap pixel decoder: display bytes in, one palette index per dot clock out.
// Assumes the fetch logic supplies bytes in line order with their row number,
// and that mode inputs come from soft-switch logic on the same clock.
//
// Overview of operation
// (RULE1) Low-res grid is 40 by 48 blocks
// (RULE2) Byte makes two stacked blocks in cell
// (RULE3) Low nibble top block, high nibble bottom
// (RULE4) Nibble picks palette entry, 0 black, 15 white
// (RULE5) Low-res uses forty-column text buffer
// (RULE6) Blocks drawn with no blank dots between
// (RULE7) High-res is 192 lines of 280 dots
// (RULE8) High-res fetch from one of two pages
// (RULE9) Bits 0..6 give seven dots, 40 bytes/line
// (RULE10) Bit 0 shifted out first, leftmost
// (RULE11) Bit 7 not shown, picks colour set
// (RULE12) Monochrome dot follows its data bit
// (RULE13) Colour dot with clear bit is black
// (RULE14) Set 0 lone dot purple even, green odd
// (RULE15) Set 1 lone dot blue even, orange odd
// (RULE16) Two adjacent lit dots are both white
// (RULE17) Colour set applies to whole byte
// (RULE18) Colour cell spans two dots, 140 cells
// (RULE19) Double mode: 192 lines of 560 dots
// (RULE20) Double uses main and aux, bit 7 hidden
// (RULE21) Aux byte dots first, then main byte
// (RULE22) Double colour from four-dot sliding window
// (RULE23) Double enable turns high-res into double
// (RULE24) Mixed mode: text replaces bottom 32 rows
// (RULE25) One four-bit palette index per dot clock
`timescale 1ns/1ns
`default_nettype none
module lgpd_pixel_decoder (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Display mode controls
  input wire logic bitmap_mode_select_in,
  input wire logic double_resolution_enable_in,
  input wire logic mixed_mode_in,
  input wire logic page_select_in,
  // Display bytes from fetch logic
  input wire logic byte_valid_in,
  output logic byte_ready_out,
  input wire logic [7:0] byte_main_in,
  input wire logic [7:0] byte_aux_in,
  input wire logic [7:0] byte_row_in,
  // Fetch buffer base
  output logic [15:0] fetch_base_out,
  // Dot stream to video encoder
  output logic dot_valid_out,
  input wire logic dot_ready_in,
  output logic [3:0] dot_index_out,
  output logic dot_mono_out,
  output logic dot_text_out,
  output logic dot_first_out
);

  // ==========================================================
  // Helper functions
  function automatic logic dot_bit(input logic [7:0] aux, input logic [7:0] main,
                                   input logic dbl, input logic [3:0] cnt);
    logic [15:0] bits;
    bits = dbl ? {2'b00, main[6:0], aux[6:0]} : {9'h000, main[6:0]};
    return bits[cnt];
  endfunction

  function automatic logic [3:0] dhr_index(input logic [3:0] bits, input logic [1:0] ph);
    logic [3:0] idx;
    logic [1:0] p;
    idx = 4'h0;
    for (int i = 0; i < 4; i++) begin
      p = ph + 2'(i);
      idx[p] = bits[i];
    end
    return idx;
  endfunction

  // ==========================================================
  // Byte FIFO
  logic fifo_valid;
  logic fifo_ready;
  logic [lgpd_pkg::WORD_WIDTH-1:0] fifo_word;

  lgpd_fifo #(
    .WIDTH(lgpd_pkg::WORD_WIDTH),
    .DEPTH(lgpd_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .wr_valid_in(byte_valid_in),
    .wr_ready_out(byte_ready_out),
    .wr_data_in({byte_row_in, byte_aux_in, byte_main_in}),
    .rd_valid_out(fifo_valid),
    .rd_ready_in(fifo_ready),
    .rd_data_out(fifo_word)
  );

  // ==========================================================
  // Serialiser state
  lgpd_pkg::lgpd_state_type state_reg;
  lgpd_pkg::lgpd_mode_type mode_reg;
  lgpd_pkg::lgpd_mode_type eff_mode;
  logic [3:0] cnt_reg;
  logic [5:0] byte_cnt_reg;
  logic [9:0] col_reg;
  logic [7:0] main_reg;
  logic [7:0] aux_reg;
  logic [7:0] row_reg;
  logic mixed_reg;
  logic [15:0] fetch_base_reg;

  logic r_bit;
  logic r_pad;
  logic r_text;
  logic [3:0] r_nibble;
  logic last_dot;
  logic line_end;
  logic stall;
  logic adv;
  logic load;

  // Double enable turns bitmap select into double mode
  // (RULE23) mode resolution
  always_comb begin
    if (!bitmap_mode_select_in) begin
      eff_mode = lgpd_pkg::LGPD_LORES;
    end else if (double_resolution_enable_in) begin
      eff_mode = lgpd_pkg::LGPD_DOUBLE;
    end else begin
      eff_mode = lgpd_pkg::LGPD_SINGLE;
    end
  end

  // (RULE10) low bit first
  // (RULE20) seven bits of each byte
  // (RULE21) aux dots lead
  assign r_bit = !r_pad && dot_bit(aux_reg, main_reg, mode_reg == lgpd_pkg::LGPD_DOUBLE, cnt_reg);
  assign r_pad = state_reg == lgpd_pkg::LGPD_PAD;
  // (RULE2) row bit 2 picks cell half
  // (RULE3) nibble to block
  assign r_nibble = row_reg[lgpd_pkg::LORES_HALF_BIT] ? main_reg[7:4] : main_reg[3:0];
  // (RULE24) bottom rows to text
  assign r_text = mixed_reg && (row_reg >= lgpd_pkg::MIX_FIRST_ROW);
  // (RULE19) fourteen dots double
  assign last_dot = cnt_reg == ((mode_reg == lgpd_pkg::LGPD_DOUBLE) ?
                    lgpd_pkg::DOUBLE_LAST_DOT : lgpd_pkg::SINGLE_LAST_DOT);
  // (RULE1) forty block columns
  // (RULE9) forty bytes per line
  assign line_end = byte_cnt_reg == lgpd_pkg::LAST_BYTE;
  assign stall = dot_valid_out && !dot_ready_in;
  assign adv = !stall && (state_reg != lgpd_pkg::LGPD_IDLE);
  assign fifo_ready = (state_reg == lgpd_pkg::LGPD_IDLE) ||
                      (adv && (r_pad || (last_dot && !line_end)));
  assign load = fifo_ready && fifo_valid;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state_reg <= lgpd_pkg::LGPD_IDLE;
    end else if (load) begin
      state_reg <= lgpd_pkg::LGPD_SHIFT;
    end else if (adv) begin
      unique case (state_reg)
        lgpd_pkg::LGPD_SHIFT: begin
          if (last_dot) begin
            state_reg <= line_end ? lgpd_pkg::LGPD_PAD : lgpd_pkg::LGPD_IDLE;
          end
        end
        lgpd_pkg::LGPD_PAD: begin
          state_reg <= lgpd_pkg::LGPD_IDLE;
        end
        default: begin
          state_reg <= lgpd_pkg::LGPD_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      cnt_reg <= 4'h0;
    end else if (load) begin
      cnt_reg <= 4'h0;
    end else if (adv && !r_pad) begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      byte_cnt_reg <= 6'h00;
    end else if (adv && !r_pad && last_dot) begin
      byte_cnt_reg <= line_end ? 6'h00 : byte_cnt_reg + 6'h01;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      col_reg <= 10'h000;
    end else if (adv) begin
      col_reg <= r_pad ? 10'h000 : col_reg + 10'h001;
    end
  end

  // Mode is taken per byte, so a mode change waits for the next byte load
  // (RULE5) held bytes keep their mode
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      main_reg <= 8'h00;
      aux_reg <= 8'h00;
      row_reg <= 8'h00;
      mode_reg <= lgpd_pkg::LGPD_LORES;
      mixed_reg <= 1'b0;
    end else if (load) begin
      main_reg <= fifo_word[lgpd_pkg::MAIN_LSB +: 8];
      aux_reg <= fifo_word[lgpd_pkg::AUX_LSB +: 8];
      row_reg <= fifo_word[lgpd_pkg::ROW_LSB +: 8];
      mode_reg <= eff_mode;
      mixed_reg <= mixed_mode_in;
    end
  end

  // (RULE8) page base for fetch
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      fetch_base_reg <= lgpd_pkg::TEXT_PAGE1;
    end else if (bitmap_mode_select_in) begin
      fetch_base_reg <= page_select_in ? lgpd_pkg::BITMAP_PAGE2 : lgpd_pkg::BITMAP_PAGE1;
    end else begin
      fetch_base_reg <= page_select_in ? lgpd_pkg::TEXT_PAGE2 : lgpd_pkg::TEXT_PAGE1;
    end
  end
  assign fetch_base_out = fetch_base_reg;

  // ==========================================================
  // Neighbour window: w0 is the dot being resolved, r_bit its right side
  logic w0_valid_reg;
  logic w0_pad_reg;
  logic w0_bit_reg;
  logic w0_first_reg;
  logic [1:0] w0_col_reg;
  logic w0_colset_reg;
  lgpd_pkg::lgpd_mode_type w0_mode_reg;
  logic [3:0] w0_nibble_reg;
  logic w0_text_reg;
  logic w1_bit_reg;
  logic w2_bit_reg;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      w0_valid_reg <= 1'b0;
      w0_pad_reg <= 1'b0;
      w0_bit_reg <= 1'b0;
      w0_first_reg <= 1'b0;
      w0_col_reg <= 2'b00;
      w0_colset_reg <= 1'b0;
      w0_mode_reg <= lgpd_pkg::LGPD_LORES;
      w0_nibble_reg <= 4'h0;
      w0_text_reg <= 1'b0;
      w1_bit_reg <= 1'b0;
      w2_bit_reg <= 1'b0;
    end else if (adv) begin
      w0_valid_reg <= 1'b1;
      w0_pad_reg <= r_pad;
      w0_bit_reg <= r_bit;
      w0_first_reg <= col_reg == 10'h000;
      w0_col_reg <= col_reg[1:0];
      // (RULE17) set taken per byte
      w0_colset_reg <= main_reg[lgpd_pkg::COLSET_BIT];
      w0_mode_reg <= mode_reg;
      w0_nibble_reg <= r_nibble;
      w0_text_reg <= r_text;
      w1_bit_reg <= w0_bit_reg;
      w2_bit_reg <= w0_pad_reg ? 1'b0 : w1_bit_reg;
    end
  end

  // ==========================================================
  // Colour resolution
  logic emit;
  logic left_bit;
  logic [3:0] idx_next;
  logic mono_next;

  assign emit = adv && w0_valid_reg && !w0_pad_reg;
  assign left_bit = !w0_first_reg && w1_bit_reg;

  always_comb begin
    idx_next = lgpd_pkg::COL_BLACK;
    mono_next = w0_bit_reg;
    unique case (w0_mode_reg)
      lgpd_pkg::LGPD_LORES: begin
        // (RULE4) nibble is palette index
        // (RULE6) every dot of the block lit
        idx_next = w0_nibble_reg;
        mono_next = |w0_nibble_reg;
      end
      lgpd_pkg::LGPD_SINGLE: begin
        // (RULE13) clear bit is black
        if (!w0_bit_reg) begin
          idx_next = lgpd_pkg::COL_BLACK;
        // (RULE16) lit pair is white
        end else if (left_bit || r_bit) begin
          idx_next = lgpd_pkg::COL_WHITE;
        // (RULE18) parity picks cell half
        // (RULE14) set zero colours
        end else if (!w0_colset_reg) begin
          idx_next = w0_col_reg[0] ? lgpd_pkg::COL_GREEN : lgpd_pkg::COL_PURPLE;
        // (RULE15) set one colours
        end else begin
          idx_next = w0_col_reg[0] ? lgpd_pkg::COL_ORANGE : lgpd_pkg::COL_BLUE;
        end
      end
      lgpd_pkg::LGPD_DOUBLE: begin
        // (RULE22) four-dot window colour
        idx_next = dhr_index({r_bit, w0_bit_reg, w1_bit_reg, w2_bit_reg},
                             w0_col_reg - 2'b10);
      end
      default: begin
        idx_next = lgpd_pkg::COL_BLACK;
      end
    endcase
    if (w0_text_reg) begin
      idx_next = lgpd_pkg::COL_BLACK;
      mono_next = 1'b0;
    end
  end

  // ==========================================================
  // Output stage, one dot per clock while the encoder accepts
  logic [3:0] dot_index_reg;
  logic dot_valid_reg;
  logic dot_mono_reg;
  logic dot_text_reg;
  logic dot_first_reg;

  // (RULE25) index per dot clock
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      dot_valid_reg <= 1'b0;
    end else if (!stall) begin
      dot_valid_reg <= emit;
    end
  end

  // (RULE12) mono follows bit
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      dot_index_reg <= lgpd_pkg::COL_BLACK;
      dot_mono_reg <= 1'b0;
      dot_text_reg <= 1'b0;
      dot_first_reg <= 1'b0;
    end else if (emit) begin
      dot_index_reg <= idx_next;
      dot_mono_reg <= mono_next;
      dot_text_reg <= w0_text_reg;
      dot_first_reg <= w0_first_reg;
    end
  end

  assign dot_valid_out = dot_valid_reg;
  assign dot_index_out = dot_index_reg;
  assign dot_mono_out = dot_mono_reg;
  assign dot_text_out = dot_text_reg;
  assign dot_first_out = dot_first_reg;

  // ==========================================================
  // Checks
  a_zero_dot_black: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE13
    emit && w0_mode_reg == lgpd_pkg::LGPD_SINGLE && !w0_bit_reg && !w0_text_reg
    |=> dot_index_out == lgpd_pkg::COL_BLACK)
    else $error("clear high-res bit not black");

  a_lit_pair_white: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE16
    emit && w0_mode_reg == lgpd_pkg::LGPD_SINGLE && w0_bit_reg && r_bit && !w0_text_reg
    |=> dot_index_out == lgpd_pkg::COL_WHITE)
    else $error("adjacent lit dots not white");

  a_set_zero_colour: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE14
    emit && w0_mode_reg == lgpd_pkg::LGPD_SINGLE && w0_bit_reg && !left_bit && !r_bit
    && !w0_colset_reg && !w0_text_reg
    |=> dot_index_out == ($past(w0_col_reg[0]) ? lgpd_pkg::COL_GREEN : lgpd_pkg::COL_PURPLE))
    else $error("lone dot wrong in set zero");

  a_set_one_colour: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE15
    emit && w0_mode_reg == lgpd_pkg::LGPD_SINGLE && w0_bit_reg && !left_bit && !r_bit
    && w0_colset_reg && !w0_text_reg
    |=> dot_index_out == ($past(w0_col_reg[0]) ? lgpd_pkg::COL_ORANGE : lgpd_pkg::COL_BLUE))
    else $error("lone dot wrong in set one");

  a_lores_nibble: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE3
    emit && w0_mode_reg == lgpd_pkg::LGPD_LORES && !w0_text_reg
    |=> dot_index_out == $past(w0_nibble_reg) && dot_mono_out == (|dot_index_out))
    else $error("low-res nibble not routed");

  // (RULE7) 280 dots per line, (RULE19) 560 in double mode
  a_line_length: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE9
    adv && r_pad |-> col_reg == ((mode_reg == lgpd_pkg::LGPD_DOUBLE) ?
      lgpd_pkg::DOUBLE_LINE_DOTS : lgpd_pkg::SINGLE_LINE_DOTS))
    else $error("line dot count wrong");

  a_top_bit_hidden: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE11
    state_reg == lgpd_pkg::LGPD_SHIFT |-> cnt_reg <= ((mode_reg == lgpd_pkg::LGPD_DOUBLE) ?
      lgpd_pkg::DOUBLE_LAST_DOT : lgpd_pkg::SINGLE_LAST_DOT))
    else $error("dot counter ran into bit 7");

  a_mono_follow: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE12
    emit && w0_mode_reg != lgpd_pkg::LGPD_LORES && !w0_text_reg
    |=> dot_mono_out == $past(w0_bit_reg))
    else $error("mono dot differs from bit");

  a_mixed_text: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE24
    emit && w0_text_reg |=> dot_text_out && dot_index_out == lgpd_pkg::COL_BLACK)
    else $error("text rows not marked");

  a_output_hold: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE25
    stall |=> dot_valid_out && $stable(dot_index_out))
    else $error("dot dropped under back-pressure");

endmodule
`default_nettype wire

// >>> testbench/lgpd_encoder_model.sv
// Video encoder model: takes dots promptly, with random stalls, or not at all.
// Assumes it shares clk_in with the decoder; the bench sets hold and pace.
`timescale 1ns/1ns
`default_nettype none
module lgpd_encoder_model (
  // Clock
  input wire logic clk_in,
  // Pace control
  input wire logic hold_in,
  input wire logic slow_in,
  // Dot acceptance
  output var logic dot_ready_out
);
  // ==========================================================
  // Acceptance pace, changed just after each rising edge
  always @(posedge clk_in) begin
    dot_ready_out <= !hold_in && (!slow_in || ($urandom % 3) != 0);
  end
endmodule
`default_nettype wire

// >>> testbench/lgpd_pixel_decoder_tb_top.sv
// Testbench for the bitmap pixel decoder: drives byte words, predicts every dot.
// Assumes the encoder model beside it and the design under hw/.
`timescale 1ns/1ns
`default_nettype none
module lgpd_pixel_decoder_tb_top;
  logic clk_in, resetn_in, bm, dbl, mix, pg, bv, hold, slow;
  logic [7:0] bmain, baux, brow;
  logic byte_ready_out, dot_valid_out, dot_ready_in, dot_mono_out, dot_text_out, dot_first_out;
  logic [15:0] fetch_base_out;
  logic [3:0] dot_index_out;
  logic [7:0] mb [40];
  logic [7:0] ab [40];
  logic [6:0] q [$];
  int fails, tests_run, i;
  logic [15:0] exp_base;
  logic [6:0] got_dot;

  assign got_dot = {dot_text_out, dot_first_out, dot_mono_out, dot_index_out};

  // ==========================================================
  // Design and encoder model
  lgpd_pixel_decoder lgpd_pixel_decoder_i (
    .clk_in(clk_in), .resetn_in(resetn_in), .bitmap_mode_select_in(bm),
    .double_resolution_enable_in(dbl), .mixed_mode_in(mix), .page_select_in(pg),
    .byte_valid_in(bv), .byte_ready_out(byte_ready_out), .byte_main_in(bmain),
    .byte_aux_in(baux), .byte_row_in(brow), .fetch_base_out(fetch_base_out),
    .dot_valid_out(dot_valid_out), .dot_ready_in(dot_ready_in),
    .dot_index_out(dot_index_out), .dot_mono_out(dot_mono_out),
    .dot_text_out(dot_text_out), .dot_first_out(dot_first_out));
  lgpd_encoder_model lgpd_encoder_model_i (
    .clk_in(clk_in), .hold_in(hold), .slow_in(slow), .dot_ready_out(dot_ready_in));

  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  // ==========================================================
  // Verdict and comparisons
  task automatic results();
    if (fails == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic fail_out();
    fails++;
    results();
  endtask

  task automatic chk_dot(input logic [6:0] exp, input logic [6:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] dot exp %h got %h", exp, got);
    end
  endtask

  task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s exp %h got %h", what, exp, got);
    end
  endtask

  // Oldest prediction against each dot the encoder takes
  always @(posedge clk_in) begin
    if (resetn_in && dot_valid_out === 1'b1 && dot_ready_in === 1'b1) begin
      if (q.size() == 0) begin
        fails++;
        $display("[FAIL] dot exp none got %h", dot_index_out);
      end else begin
        chk_dot(q.pop_front(), got_dot);
      end
    end
  end

  // ==========================================================
  // Byte driver and line predictor
  task automatic send_word(input logic [7:0] m, input logic [7:0] a, input logic [7:0] r);
    int n;
    n = 0;
    @(negedge clk_in);
    bv = 1'b1;
    bmain = m;
    baux = a;
    brow = r;
    while (byte_ready_out !== 1'b1) begin
      @(negedge clk_in);
      n++;
      if (n > 2000) fail_out();
    end
  endtask

  task automatic fill_rand();
    for (int k = 0; k < 40; k++) begin
      mb[k] = 8'($urandom);
      ab[k] = 8'($urandom);
    end
  endtask

  task automatic run_line(input logic b, input logic d, input logic x, input logic [7:0] row);
    logic bits [560];
    logic [3:0] ix;
    logic l, r, s, m, t;
    int n, c, j, w;
    @(negedge clk_in);
    bm = b;
    dbl = d;
    mix = x;
    n = (b && d) ? 560 : 280;
    for (c = 0; c < n; c++) begin
      w = (b && d) ? c / 14 : c / 7;
      bits[c] = (b && d && (c / 7) % 2 == 0) ? ab[w][c % 7] : mb[w][c % 7];
    end
    for (c = 0; c < n; c++) begin
      l = (c > 0) && bits[c - 1];
      r = (c < n - 1) && bits[c + 1];
      if (!b) begin
        ix = row[lgpd_pkg::LORES_HALF_BIT] ? mb[c / 7][7:4] : mb[c / 7][3:0];
      end else if (!d) begin
        s = mb[c / 7][lgpd_pkg::COLSET_BIT];
        if (!bits[c]) ix = lgpd_pkg::COL_BLACK;
        else if (l || r) ix = lgpd_pkg::COL_WHITE;
        else if (c % 2 == 0) ix = s ? lgpd_pkg::COL_BLUE : lgpd_pkg::COL_PURPLE;
        else ix = s ? lgpd_pkg::COL_ORANGE : lgpd_pkg::COL_GREEN;
      end else begin
        ix = 4'h0;
        for (j = c - 2; j <= c + 1; j++) begin
          if (j >= 0 && j < n && bits[j]) ix[j % 4] = 1'b1;
        end
      end
      m = b ? bits[c] : |ix;
      t = x && row >= 8'hA0;
      q.push_back(t ? {1'b1, c == 0, 5'h00} : {1'b0, c == 0, m, ix});
    end
    for (w = 0; w < 40; w++) send_word(mb[w], ab[w], row);
    @(negedge clk_in);
    bv = 1'b0;
    w = 0;
    while (q.size() > 0) begin
      @(negedge clk_in);
      w++;
      if (w > 3000) fail_out();
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    fails = 0;
    tests_run = 0;
    resetn_in = 1'b0;
    {bm, dbl, mix, pg, bv, hold} = 6'h00;
    slow = 1'b1;
    {bmain, baux, brow} = 24'h000000;
    void'($urandom(32'hE3A0));
    repeat (12) @(negedge clk_in);
    resetn_in = 1'b1;
    @(negedge clk_in);
    chk_val("ready_after_reset", 16'h0001, {15'h0000, byte_ready_out});
    for (i = 0; i < 8; i++) begin
      @(negedge clk_in);
      {bm, dbl, pg} = 3'(i);
      repeat (3) @(negedge clk_in);
      exp_base = bm ? (pg ? lgpd_pkg::BITMAP_PAGE2 : lgpd_pkg::BITMAP_PAGE1)
                    : (pg ? lgpd_pkg::TEXT_PAGE2 : lgpd_pkg::TEXT_PAGE1);
      chk_val("fetch_base", exp_base, fetch_base_out);
    end
    pg = 1'b0;
    fill_rand();
    mb[0] = 8'hF0;
    mb[1] = 8'h0F;
    run_line(1'b0, 1'b0, 1'b0, 8'h03);
    fill_rand();
    run_line(1'b0, 1'b1, 1'b0, 8'h04);
    fill_rand();
    {mb[0], mb[1], mb[2], mb[3]} = 32'h55D52AAA;
    run_line(1'b1, 1'b0, 1'b0, 8'h00);
    fill_rand();
    run_line(1'b1, 1'b1, 1'b0, 8'h0A);
    fill_rand();
    run_line(1'b1, 1'b0, 1'b1, 8'h9F);
    run_line(1'b1, 1'b0, 1'b1, 8'hA0);
    run_line(1'b1, 1'b1, 1'b1, 8'hBF);
    slow = 1'b0;
    hold = 1'b1;
    fill_rand();
    fork
      run_line(1'b1, 1'b0, 1'b0, 8'h20);
      begin
        repeat (60) @(negedge clk_in);
        chk_val("ready_when_full", 16'h0000, {15'h0000, byte_ready_out});
        hold = 1'b0;
      end
    join
    chk_val("ready_when_drained", 16'h0001, {15'h0000, byte_ready_out});
    results();
  end

  initial begin
    repeat (90000) @(posedge clk_in);
    fail_out();
  end
endmodule
`default_nettype wire
